// ==== src/cdd_decoder.sv ====
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "cdd_map.svh"
// How it works
// - clear fills blanks, zeroes counter, within 6.2ms
// - home zeroes counter and display shift
// - entry mode stores direction and shift
// - display control stores enable, cursor, blink
// - shift instruction moves cursor or display
// - mode instruction stores graphic and power bits
// - function set stores width, lines, glyph, font
// - glyph address loads counter, selects glyph ram
// - display address loads counter, selects display ram
// - status read returns busy and counter
// - data write stores byte in selected ram
// - data read returns byte from selected ram
// - counter steps after data access, busy ends
// - busy blocks everything but status and config reads
// - graphic one means graphic; power one on
module cdd_decoder
  import cdd_pkg::*;
#(
  parameter int unsigned CLEAR_CYCLES = `CDD_CLEAR_CYC
)(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_busy,
  output cdd_cfg_t o_cfg,
  output logic [6:0] o_disp_shift
);

  // ************************************************
  // decode
  // ************************************************
  logic pready_ff, busy_ff, step_pend_ff;
  cdd_state_t state_ff;
  logic [19:0] cnt_ff, clr_len_ff;
  logic [7:0] clr_idx_ff;
  logic [6:0] ac_ff, shift_ff;
  cdd_cfg_t cfg_ff;
  logic [7:0] dram [128];
  logic [7:0] gram [64];
  logic [7:0] ibyte;
  logic acc, setup, sel_instr, sel_data, sel_cfg;
  logic wr_instr, wr_data, rd_data, step_now;
  cdd_cls_t cls;
  logic [6:0] nxt_ac_step, nxt_ac_move, nxt_shift_move;
  logic [31:0] nxt_prdata;
  // highest set bit picks the class; bit 4 split by low bits
  function automatic cdd_cls_t classify(input logic [7:0] b);
    if (b[7]) return CDD_DADDR;
    if (b[6]) return CDD_GADDR;
    if (b[5]) return CDD_FUNC;
    if (b[4])
    begin
      if (b[1:0] == 2'h0) return CDD_SHIFT;
      if (b[1:0] == 2'h3) return CDD_MODE;
      return CDD_NONE;
    end
    if (b[3]) return CDD_DISP;
    if (b[2]) return CDD_ENTRY;
    if (b[1]) return CDD_HOME;
    if (b[0]) return CDD_CLEAR;
    return CDD_NONE;
  endfunction

  // access strobes, all data side blocked while busy
  assign ibyte = i_pwdata[7:0];
  assign cls = classify(ibyte);
  assign setup = i_psel & ~i_penable;
  assign acc = i_psel & i_penable & pready_ff;
  assign sel_instr = (i_paddr == `CDD_OFS_INSTR);
  assign sel_data = (i_paddr == `CDD_OFS_DATA);
  assign sel_cfg = (i_paddr == `CDD_OFS_CFG);
  assign wr_instr = acc & i_pwrite & sel_instr & ~busy_ff;
  assign wr_data = acc & i_pwrite & sel_data & ~busy_ff;
  assign rd_data = acc & ~i_pwrite & sel_data & ~busy_ff;
  assign step_now = (state_ff == CDD_BUSY_SHORT) && (cnt_ff == 20'h0)
    && step_pend_ff;

  // counter step and one-place moves
  always_comb
  begin
    nxt_ac_step = cfg_ff.inc_dir ? ac_ff + 7'h01 : ac_ff - 7'h01;
    if (cfg_ff.glyph_sel)
      nxt_ac_step = {1'b0, nxt_ac_step[5:0]};
    nxt_ac_move = ibyte[`CDD_POS_RL] ? ac_ff + 7'h01 : ac_ff - 7'h01;
    nxt_shift_move = ibyte[`CDD_POS_RL] ? shift_ff + 7'h01 : shift_ff - 7'h01;
  end

  // ************************************************
  // apb slave
  // ************************************************
  // read mux, sampled in the setup cycle
  always_comb
  begin
    nxt_prdata = 32'h0;
    if (sel_instr)
      nxt_prdata = {24'h0, busy_ff, ac_ff};
    else if (sel_data)
      nxt_prdata = {24'h0, cfg_ff.glyph_sel ? gram[ac_ff[5:0]]
        : dram[ac_ff]};
    else if (sel_cfg)
      nxt_prdata = {12'h0, shift_ff, cfg_ff};
  end
  // zero wait states; unmapped address answers with pslverr
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      pready_ff <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
    end
    else
    begin
      pready_ff <= setup;
      o_pslverr <= setup & ~(sel_instr | sel_data | sel_cfg);
      if (setup)
        o_prdata <= nxt_prdata;
    end
  end
  assign o_pready = pready_ff;
  // ************************************************
  // instruction execution
  // ************************************************
  // stored options
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      cfg_ff <= '0;
    else if (wr_instr)
    begin
      unique case (cls)
        CDD_ENTRY:
        begin
          cfg_ff.inc_dir <= ibyte[`CDD_POS_ID];
          cfg_ff.shift_on_entry <= ibyte[`CDD_POS_SH];
        end
        CDD_DISP:
        begin
          cfg_ff.disp_en <= ibyte[`CDD_POS_DEN];
          cfg_ff.cursor_en <= ibyte[`CDD_POS_CUR];
          cfg_ff.blink_en <= ibyte[`CDD_POS_BLK];
        end
        CDD_MODE:
        begin
          cfg_ff.graphic_mode <= ibyte[`CDD_POS_GC];
          cfg_ff.power_on <= ibyte[`CDD_POS_PWR];
        end
        CDD_FUNC:
        begin
          cfg_ff.bus_width_select <= ibyte[`CDD_POS_BW];
          cfg_ff.two_lines <= ibyte[`CDD_POS_N];
          cfg_ff.big_glyph <= ibyte[`CDD_POS_F];
          cfg_ff.font_table_select_hi <= ibyte[`CDD_POS_FTH];
          cfg_ff.font_table_select_lo <= ibyte[`CDD_POS_FTL];
        end
        CDD_GADDR: cfg_ff.glyph_sel <= 1'b1;
        CDD_DADDR, CDD_CLEAR, CDD_HOME: cfg_ff.glyph_sel <= 1'b0;
        CDD_SHIFT, CDD_NONE: cfg_ff.glyph_sel <= cfg_ff.glyph_sel;
      endcase
    end
  end
  // address counter
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      ac_ff <= `CDD_RST_AC;
    else if (wr_instr)
    begin
      if (cls == CDD_CLEAR || cls == CDD_HOME)
        ac_ff <= `CDD_RST_AC;
      else if (cls == CDD_GADDR)
        ac_ff <= {1'b0, ibyte[5:0]};
      else if (cls == CDD_DADDR)
        ac_ff <= ibyte[6:0];
      else if (cls == CDD_SHIFT && !ibyte[`CDD_POS_SC])
        ac_ff <= nxt_ac_move;
    end
    else if (step_now)
      ac_ff <= nxt_ac_step;
  end
  // display shift offset, ram contents untouched
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      shift_ff <= `CDD_RST_SHIFT;
    else if (wr_instr && (cls == CDD_CLEAR || cls == CDD_HOME))
      shift_ff <= `CDD_RST_SHIFT;
    else if (wr_instr && cls == CDD_SHIFT && ibyte[`CDD_POS_SC])
      shift_ff <= nxt_shift_move;
    else if (step_now && cfg_ff.shift_on_entry && !cfg_ff.glyph_sel)
      shift_ff <= cfg_ff.inc_dir ? shift_ff + 7'h01 : shift_ff - 7'h01;
  end
  // busy sequencing: long for clear, short for other decoded instructions and data accesses
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      state_ff <= CDD_IDLE;
      busy_ff <= 1'b0;
      cnt_ff <= 20'h0;
      step_pend_ff <= 1'b0;
      clr_idx_ff <= 8'h0;
    end
    else
    begin
      unique case (state_ff)
        CDD_IDLE:
        begin
          if (wr_instr && cls == CDD_CLEAR)
          begin
            state_ff <= CDD_BUSY_CLEAR;
            busy_ff <= 1'b1;
            cnt_ff <= 20'(CLEAR_CYCLES - 1);
            clr_idx_ff <= 8'h0;
          end
          else if ((wr_instr && cls != CDD_NONE) || wr_data || rd_data)
          begin
            state_ff <= CDD_BUSY_SHORT;
            busy_ff <= 1'b1;
            cnt_ff <= `CDD_SHORT_CYC - 20'h1;
            step_pend_ff <= wr_data | rd_data;
          end
        end
        CDD_BUSY_CLEAR, CDD_BUSY_SHORT:
        begin
          if (!clr_idx_ff[7])
            clr_idx_ff <= clr_idx_ff + 8'h01;
          if (cnt_ff == 20'h0)
          begin
            state_ff <= CDD_IDLE;
            busy_ff <= 1'b0;
            step_pend_ff <= 1'b0;
          end
          else
            cnt_ff <= cnt_ff - 20'h1;
        end
      endcase
    end
  end

  // ************************************************
  // ram arrays
  // ************************************************
  // display ram; clear blanking takes priority over data
  always_ff @(posedge i_mclk)
  begin
    if (state_ff == CDD_BUSY_CLEAR && !clr_idx_ff[7])
      dram[clr_idx_ff[6:0]] <= `CDD_BLANK_CHAR;
    else if (wr_data && !cfg_ff.glyph_sel)
      dram[ac_ff] <= ibyte;
  end
  // glyph ram, written only while it is selected
  always_ff @(posedge i_mclk)
  begin
    if (wr_data && cfg_ff.glyph_sel)
      gram[ac_ff[5:0]] <= ibyte;
  end
  // status outputs
  assign o_busy = busy_ff;
  assign o_cfg = cfg_ff;
  assign o_disp_shift = shift_ff;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // cycles spent so far in the clear busy state
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || state_ff != CDD_BUSY_CLEAR)
      clr_len_ff <= 20'h0;
    else
      clr_len_ff <= clr_len_ff + 20'h1;
  end
  sequence s_instr(cdd_cls_t c);
    wr_instr && cls == c;
  endsequence
  sequence s_data_acc;
    wr_data || rd_data;
  endsequence
  clear_start_a: assert property (s_instr(CDD_CLEAR) |=>
    ac_ff == 7'h0 && busy_ff && state_ff == CDD_BUSY_CLEAR)
    else $error("clear did not start correctly");
  clear_bound_a: assert property (state_ff == CDD_BUSY_CLEAR |->
    clr_len_ff < 20'(CLEAR_CYCLES))
    else $error("clear busy too long");
  home_reset_a: assert property (s_instr(CDD_HOME) |=>
    ac_ff == 7'h0 && shift_ff == 7'h0)
    else $error("home left counter or shift");
  entry_store_a: assert property (s_instr(CDD_ENTRY) |=>
    cfg_ff.inc_dir == $past(ibyte[1]) &&
    cfg_ff.shift_on_entry == $past(ibyte[0]))
    else $error("entry mode not stored");
  disp_store_a: assert property (s_instr(CDD_DISP) |=>
    {cfg_ff.disp_en, cfg_ff.cursor_en, cfg_ff.blink_en} == $past(ibyte[2:0]))
    else $error("display control not stored");
  mode_store_a: assert property (s_instr(CDD_MODE) |=>
    cfg_ff.graphic_mode == $past(ibyte[3]) &&
    cfg_ff.power_on == $past(ibyte[2]))
    else $error("mode bits not stored");
  func_store_a: assert property (s_instr(CDD_FUNC) |=>
    {cfg_ff.bus_width_select, cfg_ff.two_lines, cfg_ff.big_glyph,
    cfg_ff.font_table_select_hi, cfg_ff.font_table_select_lo}
    == $past(ibyte[4:0]))
    else $error("function set not stored");
  gaddr_load_a: assert property (s_instr(CDD_GADDR) |=>
    ac_ff == {1'b0, $past(ibyte[5:0])} && cfg_ff.glyph_sel)
    else $error("glyph address not loaded");
  daddr_load_a: assert property (s_instr(CDD_DADDR) |=>
    ac_ff == $past(ibyte[6:0]) && !cfg_ff.glyph_sel)
    else $error("display address not loaded");
  status_read_a: assert property (setup && sel_instr |=>
    o_prdata == {24'h0, $past(busy_ff), $past(ac_ff)})
    else $error("status read wrong");
  busy_block_a: assert property (busy_ff && acc && i_pwrite |=>
    $stable(cfg_ff))
    else $error("write accepted while busy");
  short_busy_a: assert property (s_data_acc |=>
    busy_ff [*2] ##1 !busy_ff)
    else $error("short busy length wrong");
  step_time_a: assert property (s_data_acc ##1 busy_ff [*2] |=>
    6'(ac_ff[5:0] - $past(ac_ff[5:0])) ==
    ($past(cfg_ff.inc_dir) ? 6'h01 : 6'h3F))
    else $error("counter did not step after busy");
endmodule

// ==== src/cdd_map.svh ====
`ifndef CDD_MAP_SVH
`define CDD_MAP_SVH
// apb register byte offsets
`define CDD_OFS_INSTR 8'h00
`define CDD_OFS_DATA 8'h04
`define CDD_OFS_CFG 8'h08
// timing
`define CDD_CLEAR_TIME_US 6200
`define CDD_MCLK_MHZ 100
`define CDD_CLEAR_CYC (`CDD_CLEAR_TIME_US * `CDD_MCLK_MHZ)
`define CDD_SHORT_CYC 20'h00002
// reset values and fill pattern
`define CDD_RST_AC 7'h00
`define CDD_RST_SHIFT 7'h00
`define CDD_RST_BYTE 8'h00
`define CDD_BLANK_CHAR 8'h20
// instruction field positions
`define CDD_POS_ID 1
`define CDD_POS_SH 0
`define CDD_POS_DEN 2
`define CDD_POS_CUR 1
`define CDD_POS_BLK 0
`define CDD_POS_SC 3
`define CDD_POS_RL 2
`define CDD_POS_GC 3
`define CDD_POS_PWR 2
`define CDD_POS_BW 4
`define CDD_POS_N 3
`define CDD_POS_F 2
`define CDD_POS_FTH 1
`define CDD_POS_FTL 0
`define CDD_POS_BUSY 7
`endif

// ==== src/cdd_pkg.sv ====
package cdd_pkg;
  // stored mode and option bits
  typedef struct packed {
    logic glyph_sel;
    logic inc_dir;
    logic shift_on_entry;
    logic disp_en;
    logic cursor_en;
    logic blink_en;
    logic graphic_mode;
    logic power_on;
    logic bus_width_select;
    logic two_lines;
    logic big_glyph;
    logic font_table_select_hi;
    logic font_table_select_lo;
  } cdd_cfg_t;

  // instruction classes
  typedef enum logic [3:0] {
    CDD_NONE, CDD_CLEAR, CDD_HOME, CDD_ENTRY, CDD_DISP,
    CDD_SHIFT, CDD_MODE, CDD_FUNC, CDD_GADDR, CDD_DADDR
  } cdd_cls_t;

  // execution states
  typedef enum logic [1:0] {
    CDD_IDLE, CDD_BUSY_CLEAR, CDD_BUSY_SHORT
  } cdd_state_t;
endpackage

// ==== verif/cdd_host.sv ====
`timescale 1ns/1ps
// ****
// host side apb master
// ****
module cdd_host (
  input wire logic i_mclk,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata
);
  // idle bus at time zero
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  // one transfer, held until pready is seen at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge i_mclk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= wr;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_mclk);
    o_penable <= 1'b1;
    @(posedge i_mclk);
    while (i_pready !== 1'b1)
      @(posedge i_mclk);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_pwdata <= ~d; // released data stops showing the old value
  endtask
  // poll status until the device is no longer busy
  task automatic wait_idle();
    logic [31:0] q;
    logic e;
    q = 32'h80;
    while (q[7] !== 1'b0)
      xfer(1'b0, 8'h00, 32'h0, q, e);
  endtask
endmodule

// ==== verif/tb_char_display_instruction_decoder.sv ====
`timescale 1ns/1ps
`include "cdd_map.svh"
module tb_char_display_instruction_decoder
  import cdd_pkg::*;
;
  localparam int CLR = 200;
  localparam logic [7:0] AI = `CDD_OFS_INSTR;
  localparam logic [7:0] AD = `CDD_OFS_DATA;
  localparam logic [7:0] AF = `CDD_OFS_CFG;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, busy, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [6:0] shift;
  cdd_cfg_t cfg;
  int n_mismatch = 0;
  int n_compared = 0;
  // ****
  // clock and instances
  // ****
  // free running clock
  always #5 i_mclk = ~i_mclk;
  // device and host
  cdd_decoder #(.CLEAR_CYCLES(CLR)) cdd_decoder_i (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_busy(busy), .o_cfg(cfg), .o_disp_shift(shift));
  cdd_host cdd_host_i (
    .i_mclk(i_mclk), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));
  // ****
  // helpers
  // ****
  // compare and count
  task automatic check(input string nm, input logic [31:0] exp,
    input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bus shorthands
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cdd_host_i.xfer(1'b1, a, {24'h0, d}, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    cdd_host_i.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wi(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    cdd_host_i.wait_idle();
  endtask
  // cycles the busy indication stays high after an access
  task automatic busy_len(output int n);
    n = 0;
    @(negedge i_mclk);
    while (busy === 1'b1 && n < 1000)
    begin
      n++;
      @(negedge i_mclk);
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    rd(AF);
    check("cfg reset", 32'h0, q);
    rd(AI);
    check("status reset", 32'h0, q);
    rd(8'h0C);
    check("unmapped err", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, q);
    wr(AF, 8'hFF);
    rd(AF);
    check("cfg read only", 32'h0, q);
    $display("done reset");
  endtask
  task automatic t_modes();
    int n;
    wi(AI, 8'h06);
    wi(AI, 8'h0F);
    wi(AI, 8'h1F);
    wi(AI, 8'h3E);
    wr(AI, 8'h19);
    busy_len(n);
    check("ignored busy", 32'h0, n);
    rd(AF);
    check("cfg", 32'h0BFE, q);
    wi(AI, 8'h13);
    check("mode off", 32'h0, {30'h0, cfg.graphic_mode, cfg.power_on});
    $display("done modes");
  endtask
  task automatic t_dram();
    wi(AI, 8'h90);
    wi(AD, 8'hA5);
    wi(AD, 8'h5A);
    rd(AI);
    check("ac inc", 32'h12, q);
    wi(AI, 8'h90);
    rd(AD);
    check("dram rd0", 32'hA5, q);
    cdd_host_i.wait_idle();
    rd(AD);
    check("dram rd1", 32'h5A, q);
    cdd_host_i.wait_idle();
    wi(AI, 8'h04);
    wi(AD, 8'h3C);
    rd(AI);
    check("ac dec", 32'h11, q);
    $display("done dram");
  endtask
  task automatic t_glyph();
    wi(AI, 8'h06);
    wi(AI, 8'h7F);
    rd(AI);
    check("gaddr", 32'h3F, q);
    wi(AD, 8'hC3);
    rd(AI);
    check("gwrap", 32'h00, q);
    wi(AI, 8'h7F);
    rd(AD);
    check("grd", 32'hC3, q);
    cdd_host_i.wait_idle();
    wi(AI, 8'h90);
    rd(AD);
    check("dram kept", 32'hA5, q);
    cdd_host_i.wait_idle();
    $display("done glyph");
  endtask
  task automatic t_shift();
    wi(AI, 8'h07);
    wi(AI, 8'h80);
    wi(AD, 8'h41);
    check("entry shift", 32'h1, {25'h0, shift});
    wi(AI, 8'h1C);
    check("disp right", 32'h2, {25'h0, shift});
    wi(AI, 8'h18);
    check("disp left", 32'h1, {25'h0, shift});
    wi(AI, 8'h14);
    rd(AI);
    check("cursor right", 32'h2, q);
    wi(AI, 8'h02);
    rd(AI);
    check("home ac", 32'h0, q);
    check("home shift", 32'h0, {25'h0, shift});
    rd(AD);
    check("home keeps", 32'h41, q);
    cdd_host_i.wait_idle();
    wi(AI, 8'h06);
    $display("done shift");
  endtask
  task automatic t_busy();
    int n;
    wr(AI, 8'h06);
    busy_len(n);
    check("short busy", 32'h2, n);
    wr(AI, 8'h01);
    busy_len(n);
    check("clear busy", CLR, n);
    rd(AI);
    check("clear ac", 32'h0, q);
    rd(AD);
    check("blank", 32'h20, q);
    cdd_host_i.wait_idle();
    wr(AI, 8'h01);
    rd(AI);
    check("busy seen", 32'h1, {31'h0, q[7]});
    wr(AD, 8'h77);
    wr(AI, 8'h90);
    cdd_host_i.wait_idle();
    rd(AI);
    check("busy refused", 32'h0, q);
    rd(AD);
    check("no busy write", 32'h20, q);
    $display("done busy");
  endtask
  // ****
  // run control
  // ****
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_reset();
    t_modes();
    t_dram();
    t_glyph();
    t_shift();
    t_busy();
    wrap_up();
  end
  // watchdog against a hung handshake
  initial
  begin
    repeat (30000) @(posedge i_mclk);
    n_mismatch++;
    wrap_up();
  end
endmodule
